// >>> crp_host.sv
// Host that builds, sends and checks coherent request packets under AXI4-Lite control
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Intervention request carries no data payload
// - Only intervention format triggers third-party intervention
// - Intervention carries origin domain, id, tag
// - Origin domain/id split configurable within transport width
// - Intervention codes 0-2; 3-15 reserved
// - Intervention format code is 1
// - Plain requests carry no data, no origin
// - Plain codes 0-7 as listed, 4 reserved
// - Plain codes 8-B as listed, C-F reserved
// - Address-only requests zero length and half select
// - Translation sync zeroes address, top bits, length
// - Plain request format code is 2
// - Format codes 3 and 4 never generated
// - Write-class packet always carries data
// - Small writes encode size with half select
// - Long writes state maximum payload size
// - Write codes 0-1; 2-15 reserved
// - Write-class format code is 5
// - Format codes 6 to 11 never generated
// - Format code is 4 bits, first field
// - Write length with half select picks lanes
// - Address carries low 29 double-word bits
module crp_host (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output crp_pkg::crp_pkt_type     tx_pkt,
   output logic                     tx_valid,
   input  wire logic                tx_ready,
   input  wire crp_pkg::crp_pkt_type rx_pkt,
   input  wire logic                rx_valid
);
   import crp_pkg::*;

   typedef enum logic [1:0] {TX_IDLE, TX_BUILD, TX_SEND} crp_txst_type;

   crp_txst_type tx_state_r;
   logic         aw_got_r;
   logic         w_got_r;
   logic [7:0]   aw_addr_r;
   logic [31:0]  w_data_r;
   logic [3:0]   w_strb_r;
   logic         is_home_r;
   logic [3:0]   domain_bits_r;
   logic [31:0]  req_r;
   logic [28:0]  addr_r;
   logic [31:0]  origin_r;
   logic [31:0]  data_lo_r;
   logic [31:0]  data_hi_r;
   logic         refused_r;
   logic         sent_r;
   logic         rx_seen_r;
   logic         rx_bad_r;
   logic [31:0]  rx_hdr_r;
   logic [28:0]  rx_addr_r;
   logic         wr_fire;
   logic         go_wr;
   logic         status_wr;
   logic [31:0]  wr_val;
   crp_pkt_type  pkt_nxt;
   logic         refuse_nxt;
   logic [3:0]   id_bits;
   logic [15:0]  origin_wide;
   logic         rx_bad_nxt;
   logic [3:0]   rx_size_nxt;

   // Byte-lane merge of the write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   assign wr_fire   = aw_got_r && w_got_r && !s_axi_bvalid;
   assign go_wr     = wr_fire && (aw_addr_r == OFS_CTRL) && w_strb_r[0] && w_data_r[0];
   assign status_wr = wr_fire && (aw_addr_r == OFS_STATUS) && w_strb_r[0];
   assign wr_val    = w_data_r;

   // AXI4-Lite write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r <= OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software-written request registers; frozen while a packet is under way
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         is_home_r     <= 1'b0;
         domain_bits_r <= DOMAIN_BITS_RST;
         req_r         <= 32'h0000_0000;
         addr_r        <= 29'h0000_0000;
         origin_r      <= 32'h0000_0000;
         data_lo_r     <= 32'h0000_0000;
         data_hi_r     <= 32'h0000_0000;
      end else if (wr_fire && tx_state_r == TX_IDLE) begin
         case (aw_addr_r)
            OFS_CONFIG: begin
               if (w_strb_r[0]) begin
                  is_home_r <= wr_val[0];
               end
               if (w_strb_r[1]) begin
                  domain_bits_r <= wr_val[11:8];
               end
            end
            OFS_REQ:     req_r     <= merge(req_r, wr_val, w_strb_r);
            OFS_ADDR:    addr_r    <= 29'(merge({3'b000, addr_r}, wr_val, w_strb_r));
            OFS_ORIGIN:  origin_r  <= merge(origin_r, wr_val, w_strb_r);
            OFS_DATA_LO: data_lo_r <= merge(data_lo_r, wr_val, w_strb_r);
            OFS_DATA_HI: data_hi_r <= merge(data_hi_r, wr_val, w_strb_r);
            default: ;
         endcase
      end
   end

   // Origin domain above origin id; split point set by software
   assign id_bits     = (domain_bits_r > 4'(ORIGIN_W)) ? 4'h0 : 4'(4'(ORIGIN_W) - domain_bits_r);
   assign origin_wide = ({8'h00, origin_r[7:0]} << id_bits) | ({8'h00, origin_r[15:8]} & ((16'h0001 << id_bits) - 16'h0001));

   // Packet builder and legality check
   always_comb begin
      pkt_nxt                      = '0;
      refuse_nxt                   = 1'b0;
      pkt_nxt.format_code          = req_r[3:0];
      pkt_nxt.transaction          = req_r[7:4];
      pkt_nxt.size_code            = req_r[11:8];
      pkt_nxt.word_half_select     = req_r[12];
      pkt_nxt.xamsbs               = req_r[14:13];
      pkt_nxt.request_tag          = req_r[23:16];
      pkt_nxt.address              = addr_r;
      case (req_r[3:0])
         FMT_INTERVENTION: begin
            pkt_nxt.has_data             = 1'b0;
            pkt_nxt.origin_field         = origin_wide[ORIGIN_W-1:0];
            pkt_nxt.origin_requester_tag = origin_r[23:16];
            pkt_nxt.dest_home            = 1'b0;
            if (req_r[7:4] > TI_LAST) begin
               refuse_nxt = 1'b1;
            end
            // Holder interventions come only from the home controller
            if (!is_home_r) begin
               refuse_nxt = 1'b1;
            end
         end
         FMT_PLAIN: begin
            pkt_nxt.has_data  = 1'b0;
            pkt_nxt.dest_home = 1'b1;
            case (req_r[7:4])
               TP_SHARED_FETCH_AT_HOME, TP_EXCLUSIVE_FETCH_AT_HOME, TP_IO_FETCH_AT_HOME,
               TP_INSTRUCTION_FETCH_AT_HOME: ;
               TP_DATA_INVALIDATE_AT_HOME, TP_INSTRUCTION_INVALIDATE_AT_HOME, TP_PURGE_WITHOUT_DATA: begin
                  pkt_nxt.size_code        = 4'h0;
                  pkt_nxt.word_half_select = 1'b0;
               end
               TP_TRANSLATION_ENTRY_INVALIDATE: begin
                  pkt_nxt.dest_home        = 1'b0;
                  pkt_nxt.size_code        = 4'h0;
                  pkt_nxt.word_half_select = 1'b0;
               end
               TP_TRANSLATION_SYNC: begin
                  pkt_nxt.dest_home        = 1'b0;
                  pkt_nxt.size_code        = 4'h0;
                  pkt_nxt.word_half_select = 1'b0;
                  pkt_nxt.address          = 29'h0000_0000;
                  pkt_nxt.xamsbs           = 2'b00;
               end
               TP_INSTRUCTION_INVALIDATE_AT_SHARER, TP_DATA_INVALIDATE_AT_SHARER: begin
                  pkt_nxt.dest_home        = 1'b0;
                  pkt_nxt.size_code        = 4'h0;
                  pkt_nxt.word_half_select = 1'b0;
                  refuse_nxt               = !is_home_r;
               end
               default: refuse_nxt = 1'b1;
            endcase
         end
         FMT_WRITE: begin
            pkt_nxt.has_data  = 1'b1;
            pkt_nxt.dest_home = 1'b1;
            pkt_nxt.data      = {data_hi_r, data_lo_r};
            // Size code passed as given: exact lanes up to a double-word, maximum beyond
            if (req_r[11:8] > WRSIZE_LAST) begin
               refuse_nxt = 1'b1;
            end
            if (req_r[7:4] > TW_LAST) begin
               refuse_nxt = 1'b1;
            end
         end
         // Reserved and undefined formats are never put on the link
         default: refuse_nxt = 1'b1;
      endcase
   end

   // Transmit sequencer: a go strobe latches, the next cycle builds, then hold until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_r <= TX_IDLE;
         tx_valid   <= 1'b0;
         tx_pkt     <= '0;
      end else begin
         case (tx_state_r)
            TX_IDLE: begin
               if (go_wr) begin
                  tx_state_r <= TX_BUILD;
               end
            end
            TX_BUILD: begin
               if (refuse_nxt) begin
                  tx_state_r <= TX_IDLE;
               end else begin
                  tx_pkt     <= pkt_nxt;
                  tx_valid   <= 1'b1;
                  tx_state_r <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_ready) begin
                  tx_valid   <= 1'b0;
                  tx_state_r <= TX_IDLE;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   // Sticky outcome flags; a new event wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refused_r <= 1'b0;
         sent_r    <= 1'b0;
      end else begin
         refused_r <= (tx_state_r == TX_BUILD && refuse_nxt) ||
                      (go_wr && tx_state_r != TX_IDLE) ||
                      (refused_r && !(status_wr && wr_val[ST_REFUSED]));
         sent_r    <= (tx_state_r == TX_SEND && tx_ready) ||
                      (sent_r && !(status_wr && wr_val[ST_SENT]));
      end
   end

   // Receive checker
   always_comb begin
      rx_bad_nxt  = 1'b0;
      rx_size_nxt = rx_pkt.size_code;
      case (rx_pkt.format_code)
         FMT_INTERVENTION: rx_bad_nxt = rx_pkt.has_data || (rx_pkt.transaction > TI_LAST);
         FMT_PLAIN: begin
            rx_bad_nxt = rx_pkt.has_data || (rx_pkt.transaction > TP_LAST) ||
                         (rx_pkt.transaction == TP_RESERVED);
            // Length code of address-only requests is not looked at
            if (rx_pkt.transaction != TP_SHARED_FETCH_AT_HOME && rx_pkt.transaction != TP_EXCLUSIVE_FETCH_AT_HOME &&
                rx_pkt.transaction != TP_IO_FETCH_AT_HOME && rx_pkt.transaction != TP_INSTRUCTION_FETCH_AT_HOME) begin
               rx_size_nxt = 4'h0;
            end
         end
         FMT_WRITE: rx_bad_nxt = !rx_pkt.has_data || (rx_pkt.transaction > TW_LAST) ||
                                 (rx_pkt.size_code > WRSIZE_LAST);
         default: rx_bad_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_seen_r <= 1'b0;
         rx_bad_r  <= 1'b0;
         rx_hdr_r  <= 32'h0000_0000;
         rx_addr_r <= 29'h0000_0000;
      end else begin
         rx_seen_r <= rx_valid || (rx_seen_r && !(status_wr && wr_val[ST_RX_SEEN]));
         rx_bad_r  <= (rx_valid && rx_bad_nxt) || (rx_bad_r && !(status_wr && wr_val[ST_RX_BAD]));
         if (rx_valid) begin
            rx_hdr_r  <= {rx_pkt.origin_field, rx_pkt.request_tag, rx_pkt.word_half_select, 3'b000,
                          rx_size_nxt, rx_pkt.transaction, rx_pkt.format_code};
            rx_addr_r <= rx_pkt.address;
         end
      end
   end

   // AXI4-Lite read channel; unmapped words read zero with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
               OFS_CTRL:    s_axi_rdata <= {31'h0000_0000, tx_state_r != TX_IDLE};
               OFS_CONFIG:  s_axi_rdata <= {20'h0_0000, domain_bits_r, 7'h00, is_home_r};
               OFS_REQ:     s_axi_rdata <= req_r;
               OFS_ADDR:    s_axi_rdata <= {3'b000, addr_r};
               OFS_ORIGIN:  s_axi_rdata <= origin_r;
               OFS_DATA_LO: s_axi_rdata <= data_lo_r;
               OFS_DATA_HI: s_axi_rdata <= data_hi_r;
               OFS_STATUS:  s_axi_rdata <= {27'h000_0000, rx_bad_r, rx_seen_r, sent_r, refused_r,
                                            tx_state_r != TX_IDLE};
               OFS_RX_HDR:  s_axi_rdata <= rx_hdr_r;
               OFS_RX_ADDR: s_axi_rdata <= {3'b000, rx_addr_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : crp_host

// >>> crp_pkg.sv
// Package: constants, register map and packet carrier for the coherent request host
package crp_pkg;
   // Format codes
   localparam logic [3:0] FMT_INTERVENTION = 4'h1;
   localparam logic [3:0] FMT_PLAIN        = 4'h2;
   localparam logic [3:0] FMT_WRITE        = 4'h5;
   // Intervention-request transaction codes
   localparam logic [3:0] TI_SHARED_FETCH_VIA_HOLDER = 4'h0;
   localparam logic [3:0] TI_EXCLUSIVE_FETCH_VIA_HOLDER = 4'h1;
   localparam logic [3:0] TI_IO_FETCH_VIA_HOLDER     = 4'h2;
   localparam logic [3:0] TI_LAST                    = 4'h2;
   // Plain request transaction codes
   localparam logic [3:0] TP_SHARED_FETCH_AT_HOME        = 4'h0;
   localparam logic [3:0] TP_EXCLUSIVE_FETCH_AT_HOME     = 4'h1;
   localparam logic [3:0] TP_IO_FETCH_AT_HOME            = 4'h2;
   localparam logic [3:0] TP_DATA_INVALIDATE_AT_HOME     = 4'h3;
   localparam logic [3:0] TP_RESERVED                    = 4'h4;
   localparam logic [3:0] TP_INSTRUCTION_INVALIDATE_AT_HOME = 4'h5;
   localparam logic [3:0] TP_TRANSLATION_ENTRY_INVALIDATE = 4'h6;
   localparam logic [3:0] TP_TRANSLATION_SYNC            = 4'h7;
   localparam logic [3:0] TP_INSTRUCTION_FETCH_AT_HOME   = 4'h8;
   localparam logic [3:0] TP_PURGE_WITHOUT_DATA          = 4'h9;
   localparam logic [3:0] TP_INSTRUCTION_INVALIDATE_AT_SHARER = 4'hA;
   localparam logic [3:0] TP_DATA_INVALIDATE_AT_SHARER   = 4'hB;
   localparam logic [3:0] TP_LAST                        = 4'hB;
   // Write-class transaction codes
   localparam logic [3:0] TW_VICTIM_WRITEBACK  = 4'h0;
   localparam logic [3:0] TW_PURGE_WITH_DATA   = 4'h1;
   localparam logic [3:0] TW_LAST              = 4'h1;
   // Write length codes above this are reserved
   localparam logic [3:0] WRSIZE_LAST          = 4'hC;
   // Combined origin domain and origin id width, set by the transport field
   localparam int unsigned ORIGIN_W            = 8;
   localparam logic [3:0] DOMAIN_BITS_RST      = 4'h4;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_CONFIG   = 8'h04;
   localparam logic [7:0] OFS_REQ      = 8'h08;
   localparam logic [7:0] OFS_ADDR     = 8'h0C;
   localparam logic [7:0] OFS_ORIGIN   = 8'h10;
   localparam logic [7:0] OFS_DATA_LO  = 8'h14;
   localparam logic [7:0] OFS_DATA_HI  = 8'h18;
   localparam logic [7:0] OFS_STATUS   = 8'h1C;
   localparam logic [7:0] OFS_RX_HDR   = 8'h20;
   localparam logic [7:0] OFS_RX_ADDR  = 8'h24;
   // Status bit positions
   localparam int unsigned ST_BUSY     = 0;
   localparam int unsigned ST_REFUSED  = 1;
   localparam int unsigned ST_SENT     = 2;
   localparam int unsigned ST_RX_SEEN  = 3;
   localparam int unsigned ST_RX_BAD   = 4;
   localparam logic [1:0] RESP_OKAY    = 2'b00;
   localparam logic [1:0] RESP_SLVERR  = 2'b10;

   typedef struct packed {
      logic [3:0]          format_code;
      logic [3:0]          transaction;
      logic [3:0]          size_code;
      logic                word_half_select;
      logic [7:0]          request_tag;
      logic [ORIGIN_W-1:0] origin_field;
      logic [7:0]          origin_requester_tag;
      logic [1:0]          xamsbs;
      logic [28:0]         address;
      logic                dest_home;
      logic                has_data;
      logic [63:0]         data;
   } crp_pkt_type;
endpackage : crp_pkg

// >>> crp_host_properties.sv
// Port checks of the request host
`timescale 1ns/1ns
module crp_host_properties (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire crp_pkg::crp_pkt_type tx_pkt,
   input wire logic                 tx_valid,
   input wire logic                 tx_ready
);
   import crp_pkg::*;
   wire logic [3:0] tc   = tx_pkt.transaction;
   wire logic       is_i = tx_valid && tx_pkt.format_code == FMT_INTERVENTION;
   wire logic       is_p = tx_valid && tx_pkt.format_code == FMT_PLAIN;
   wire logic       is_w = tx_valid && tx_pkt.format_code == FMT_WRITE;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   fmt_legal_a: assert property (tx_valid |-> is_i || is_p || is_w)
      else $error("bad format");
   code_legal_a: assert property (tx_valid |-> (is_i && tc <= TI_LAST) || (is_w && tc <= TW_LAST)
      || (is_p && tc <= TP_LAST && tc != TP_RESERVED)) else $error("reserved code");
   intv_clean_a: assert property (is_i |-> !tx_pkt.has_data && tx_pkt.data == '0 && !tx_pkt.dest_home)
      else $error("intervention dirty");
   plain_clean_a: assert property (is_p |-> !tx_pkt.has_data && tx_pkt.origin_field == '0)
      else $error("plain dirty");
   addr_only_a: assert property (is_p && tc inside {4'h3, 4'h5, 4'h6, [4'h9:4'hB]}
      |-> tx_pkt.size_code == 4'h0 && !tx_pkt.word_half_select) else $error("size not zero");
   sync_zero_a: assert property (is_p && tc == TP_TRANSLATION_SYNC |-> tx_pkt.address == '0
      && tx_pkt.xamsbs == 2'h0 && tx_pkt.size_code == 4'h0 && !tx_pkt.word_half_select) else $error("sync dirty");
   home_dest_a: assert property (is_p |-> tx_pkt.dest_home == (tc inside {[4'h0:4'h3], 4'h5, 4'h8, 4'h9}))
      else $error("bad destination");
   write_data_a: assert property (is_w |-> tx_pkt.has_data && tx_pkt.size_code <= WRSIZE_LAST)
      else $error("bad write");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_pkt))
      else $error("packet unstable");
   tx_once_a: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("packet repeated");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read");
   resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bresp stuck");
   cover property (is_i && tx_ready);
   cover property (is_w && tx_ready);
   cover property (is_p && tc == TP_TRANSLATION_SYNC && tx_ready);
endmodule : crp_host_properties

// >>> crp_link_partner.sv
// Far-end model of the packet link
`timescale 1ns/1ns
module crp_link_partner (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire crp_pkg::crp_pkt_type tx_pkt,
   input  wire logic                 tx_valid,
   output logic                     tx_ready,
   output crp_pkg::crp_pkt_type     rx_pkt,
   output logic                     rx_valid,
   input  wire logic                 slow,
   input  wire logic                 inj,
   input  wire crp_pkg::crp_pkt_type inj_pkt,
   output crp_pkg::crp_pkt_type     got_pkt,
   output logic [7:0]               got_cnt
);
   import crp_pkg::*;
   always_ff @(posedge aclk) begin
      tx_ready <= aresetn && (!slow || $urandom_range(0, 2) == 0);
   end
   // One packet per handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         got_cnt <= 8'h00;
      end else if (tx_valid && tx_ready) begin
         got_cnt <= got_cnt + 8'h01;
         got_pkt <= tx_pkt;
      end
   end
   // Injects packets
   always_ff @(posedge aclk) begin
      rx_valid <= aresetn && inj;
      rx_pkt   <= inj ? inj_pkt : ~rx_pkt;
   end
endmodule : crp_link_partner

// >>> crp_host_bench.sv
// Bench of the request host
`timescale 1ns/1ns
module crp_host_bench;
   import crp_pkg::*;
   logic        aclk, aresetn, awv, wv, bv, bready, arv, rready, slow, inj, txv, txr, rxv, awr, wrd, arr, rv, wh;
   logic [7:0]  awa, ara, cnt, tg, dm, id, ot;
   logic [31:0] wd, rd, r;
   logic [3:0]  ws, f, t, sz, db;
   logic [1:0]  br, rr, xa;
   logic [28:0] ad;
   logic [63:0] dd;
   crp_pkt_type txp, rxp, injp, got;
   int          num_errors, n_tests;
   logic [11:0] badv [13] = '{12'h100, 12'h2B0, 12'h2A0, 12'h300, 12'h400, 12'h600, 12'hB00, 12'h240, 12'h2C0,
      12'h520, 12'h50D, 12'h130, 12'h2F0};
   logic [13:0] rxt [9] = '{14'h0240, 14'h0A0B, 14'h0400, 14'h2001, 14'h3400, 14'h2980, 14'h31B3, 14'h2461, 14'h2801};
   crp_host dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .tx_pkt(txp), .tx_valid(txv), .tx_ready(txr),
      .rx_pkt(rxp), .rx_valid(rxv));
   crp_link_partner part_u (.aclk(aclk), .aresetn(aresetn), .tx_pkt(txp), .tx_valid(txv), .tx_ready(txr),
      .rx_pkt(rxp), .rx_valid(rxv), .slow(slow), .inj(inj), .inj_pkt(injp), .got_pkt(got), .got_cnt(cnt));
   task automatic chk(input string nm, input logic [159:0] got_v, input logic [159:0] exp_v);
      n_tests++;
      if (got_v !== exp_v) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp_v, got_v);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awa    <= a;
      wd     <= d;
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (bv !== 1'b1);
      bready <= 1'b0;
      chk("bresp", br, er);
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      ara    <= a;
      arv    <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rready <= 1'b0;
      d = rd;
      chk("rresp", rr, er);
   endtask : axr
   function automatic crp_pkt_type expect_pkt();
      crp_pkt_type p;
      logic [15:0] o;
      p = '0;
      o = ({8'h00, dm} << (8 - db)) | ({8'h00, id} & ((16'h1 << (8 - db)) - 16'h1));
      {p.format_code, p.transaction, p.request_tag, p.size_code} = {f, t, tg, sz};
      {p.word_half_select, p.xamsbs, p.address} = {wh, xa, ad};
      p.dest_home = f == FMT_WRITE || (f == FMT_PLAIN && t inside {[4'h0:4'h3], 4'h5, 4'h8, 4'h9});
      if (f == FMT_INTERVENTION) {p.origin_field, p.origin_requester_tag} = {o[7:0], ot};
      if (f == FMT_WRITE) {p.has_data, p.data} = {1'b1, dd};
      if (f == FMT_PLAIN && t inside {4'h3, [4'h5:4'h7], [4'h9:4'hB]}) {p.size_code, p.word_half_select} = '0;
      if (f == FMT_PLAIN && t == TP_TRANSLATION_SYNC) {p.xamsbs, p.address} = '0;
      return p;
   endfunction : expect_pkt
   task automatic rnd();
      {tg, xa, wh, dm, id} = 27'($urandom);
      {ot, ad, dd} = {8'($urandom), 29'($urandom), $urandom, $urandom};
      sz = 4'($urandom_range(0, 12));
   endtask : rnd
   task automatic send(input logic bad);
      logic [7:0] c0;
      int         k;
      c0 = cnt;
      axw(OFS_REQ, {8'h00, tg, 1'b0, xa, wh, sz, t, f}, RESP_OKAY);
      axw(OFS_ADDR, {3'b000, ad}, RESP_OKAY);
      axw(OFS_ORIGIN, {8'h00, ot, id, dm}, RESP_OKAY);
      axw(OFS_DATA_LO, dd[31:0], RESP_OKAY);
      axw(OFS_DATA_HI, dd[63:32], RESP_OKAY);
      axw(OFS_CTRL, 32'h1, RESP_OKAY);
      k = 0;
      do begin
         axr(OFS_STATUS, r, RESP_OKAY);
         k++;
      end while ((r[ST_BUSY] || r[2:1] == 2'b00) && k < 60);
      chk("refused", r[ST_REFUSED], bad);
      chk("count", 8'(cnt - c0), {7'h00, !bad});
      if (!bad) chk("packet", got, expect_pkt());
      axw(OFS_STATUS, 32'h6, RESP_OKAY);
   endtask : send
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      #3_000_000;
      num_errors++;
      finish_test();
   end
   initial begin
      {aresetn, awv, wv, bready, arv, rready, slow, inj, awa, ara, wd, injp, db} = '0;
      ws = 4'hF;
      void'($urandom(32'h80c7));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(OFS_CONFIG, r, RESP_OKAY);
      chk("config", r, {20'h0, DOMAIN_BITS_RST, 8'h00});
      axr(8'h30, r, RESP_SLVERR);
      chk("unmapped", r, 32'h0);
      axw(8'h40, 32'h0, RESP_SLVERR);
      $display("map done");
      for (int i = 0; i < 13; i++) begin
         rnd();
         if (i == 11) axw(OFS_CONFIG, 32'h401, RESP_OKAY);
         {f, t, sz} = badv[i];
         send(1'b1);
      end
      $display("refusals done");
      for (int i = 0; i < 32; i++) begin
         rnd();
         db = 4'($urandom_range(0, 8));
         axw(OFS_CONFIG, {20'h0, db, 8'h01}, RESP_OKAY);
         slow <= i[0];
         f = i % 16 < 3 ? FMT_INTERVENTION : i % 16 < 14 ? FMT_PLAIN : FMT_WRITE;
         t = i % 16 < 3 ? 4'(i % 16) : i % 16 < 14 ? 4'(i % 16 - 3 + (i % 16 >= 7)) : 4'(i % 16 - 14);
         if (i == 15) sz = WRSIZE_LAST;
         send(1'b0);
      end
      $display("legal done");
      for (int i = 0; i < 9; i++) begin
         rnd();
         injp <= '{format_code: rxt[i][12:9], transaction: rxt[i][8:5], size_code: rxt[i][4:1],
                   has_data: rxt[i][0], request_tag: tg, default: '0};
         inj  <= 1'b1;
         @(posedge aclk);
         inj  <= 1'b0;
         axr(OFS_STATUS, r, RESP_OKAY);
         chk("rx flags", r[4:3], {rxt[i][13], 1'b1});
         axr(OFS_RX_HDR, r, RESP_OKAY);
         if (!rxt[i][13]) chk("rx header", r & 32'hFFFF8FFF, {16'(tg), 4'h0, rxt[i][4:1], rxt[i][8:5], rxt[i][12:9]});
         axw(OFS_STATUS, 32'h18, RESP_OKAY);
      end
      $display("receive done");
      finish_test();
   end
endmodule : crp_host_bench
bind crp_host crp_host_properties chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .tx_pkt(tx_pkt), .tx_valid(tx_valid), .tx_ready(tx_ready));
